// ==== src/apm_device.sv ====
`timescale 1ns/1ps
// Contract
// R1: Mode 00, standby low: power down when idle
// R2: Mode 00, standby high: always normal
// R3: Mode 01: normal regardless of standby
// R4: Mode 10: full power-down always
// R5: Mode 11: partial power-down when not converting
// R6: Between-conversions: power down when busy falls
// R7: Start falling edge wakes, ready after 5 us
// R8: Host holds start low 5 us on wake
// R9: Host writes power-up before software conversion; host code sends power-up in the conversion write itself
// R10: No automatic partial power-down after calibration
// R11: Host three writes for partial-mode calibration
// R12: Standby ignored during power-up autocalibration
// R13: Calibrate high at power-up skips autocalibration
// R14: Host idles about 32 ms after power-up
// R15: Host delays self-calibration by power-up time
// R16: Host uses partial power-down for long sleeps
// R17: Calibration raises busy until it completes
// R18: Mode write takes effect at write completion
module apm_device
  import apm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  apm_if.dev        bus
);
  import apm_pkg::*;

  logic [1:0] start_s_q, cal_s_q, stby_s_q;
  logic       start_d1_q, cal_d1_q;
  logic [1:0] mode_q;
  apm_pwr_t   st_q, st_d;
  logic       conv_q, cal_q, autocal_q, first_q;
  logic [CNT_W-1:0] cnt_q;

  // Pins pass two flops before logic reads them, except the calibrate strap read raw on the first cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_s_q <= 2'h3;
      cal_s_q   <= 2'h3;
      stby_s_q  <= 2'h0;
    end else if (clk_en) begin
      start_s_q <= {start_s_q[0], bus.conversion_start_n};
      cal_s_q   <= {cal_s_q[0], bus.calibrate_n};
      stby_s_q  <= {stby_s_q[0], bus.standby_n};
    end
  end

  wire start_fall = start_d1_q & ~start_s_q[1];
  wire start_rise = ~start_d1_q & start_s_q[1];
  wire cal_rise   = ~cal_d1_q & cal_s_q[1];
  wire stby_high  = stby_s_q[1];
  wire busy_w     = conv_q | cal_q;
  wire cnt_done   = (cnt_q == CNT_ZERO);
  wire sw_cal     = bus.wr_valid & bus.wr_calibrate;
  wire sw_conv    = bus.wr_valid & bus.wr_start_conv;
  wire cal_go     = (cal_rise | sw_cal) & ~busy_w;
  // Conversion starts only when powered; a powered-down part ignores it
  wire conv_go    = (start_rise | sw_conv) & ~busy_w & (st_q == APM_ST_NORMAL);
  // Incoming mode acts on the edge that completes the write
  wire [1:0] mode_d = bus.wr_valid ? bus.wr_mode : mode_q;                 // R18
  wire pd_between = (mode_d == APM_MODE_PIN) & ~stby_high & ~autocal_q;        // R1 R12

  // Target state when idle
  always_comb begin
    st_d = st_q;
    unique case (mode_d)
      APM_MODE_UP:   st_d = APM_ST_NORMAL;                                 // R3
      APM_MODE_FULL: st_d = APM_ST_FULL_PD;                                // R4
      APM_MODE_PART: st_d = busy_w ? APM_ST_NORMAL : APM_ST_PART_PD;       // R5
      APM_MODE_PIN: begin
        if (!pd_between) st_d = APM_ST_NORMAL;                             // R2
        else if (busy_w) st_d = APM_ST_NORMAL;
        else if (st_q == APM_ST_WAKING) st_d = APM_ST_WAKING;
        else if (start_fall) st_d = APM_ST_WAKING;                         // R7
        // Stay up only while a start pulse is pending, else sleep
        else if (st_q == APM_ST_NORMAL && (!start_s_q[1] || start_rise))
          st_d = APM_ST_NORMAL;
        else st_d = APM_ST_FULL_PD;                                        // R1
      end
    endcase
    // Leaving power-down by a mode write or pin also needs the wake time
    if (st_d == APM_ST_NORMAL && (st_q == APM_ST_FULL_PD || st_q == APM_ST_PART_PD)
        && !busy_w)
      st_d = APM_ST_WAKING;
    if (st_q == APM_ST_WAKING && st_d == APM_ST_WAKING && cnt_done)
      st_d = APM_ST_NORMAL;
    // A wake by mode or pin still serves the full wake time
    if (st_q == APM_ST_WAKING && st_d == APM_ST_NORMAL && !cnt_done && !busy_w)
      st_d = APM_ST_WAKING;                                                // R7
    // Conversion end in between-conversions mode drops straight to full power-down
    if (pd_between && conv_q && cnt_done) st_d = APM_ST_FULL_PD;          // R6
  end

  // Mode register; updated as the write completes
  always_ff @(posedge sys_clk) begin
    if (rst) mode_q <= APM_MODE_RESET;                                     // R1
    else if (clk_en && bus.wr_valid) mode_q <= bus.wr_mode;                // R18
  end

  // Calibrate strap caught on the first enabled cycle after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      first_q   <= 1'b1;
      autocal_q <= 1'b0;
      cal_q     <= 1'b0;
      conv_q    <= 1'b0;
      start_d1_q <= 1'b1;
      cal_d1_q  <= 1'b1;
      cnt_q     <= CNT_ZERO;
      st_q      <= APM_ST_NORMAL;
    end else if (clk_en) begin
      first_q    <= 1'b0;
      start_d1_q <= start_s_q[1];
      cal_d1_q   <= cal_s_q[1];
      st_q       <= st_d;
      if (first_q) begin
        // Calibrate held low means run autocalibration
        autocal_q <= ~bus.calibrate_n;                                     // R13
        cal_q     <= ~bus.calibrate_n;                                     // R17
        cnt_q     <= CNT_W'(CAL_CYC);
      end else if (cal_go) begin
        cal_q <= 1'b1;                                                     // R17
        cnt_q <= CNT_W'(CAL_CYC);
      end else if (conv_go) begin
        conv_q <= 1'b1;
        cnt_q  <= CNT_W'(CONV_CYC);
      end else if (st_q != APM_ST_WAKING && st_d == APM_ST_WAKING) begin
        cnt_q <= CNT_W'(WAKE_CYC - 1);                                     // R7
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        // Calibration end leaves state as commanded, never auto partial
        cal_q     <= 1'b0;                                                 // R10
        autocal_q <= 1'b0;
        conv_q    <= 1'b0;
      end
    end
  end

  assign bus.busy        = busy_w;                                         // R17
  assign bus.power_state = st_q;
endmodule

// ==== pkg/apm_pkg.sv ====
package apm_pkg;
  // Power-mode field encodings, high bit first
  localparam logic [1:0] APM_MODE_PIN   = 2'h0;
  localparam logic [1:0] APM_MODE_UP    = 2'h1;
  localparam logic [1:0] APM_MODE_FULL  = 2'h2;
  localparam logic [1:0] APM_MODE_PART  = 2'h3;
  localparam logic [1:0] APM_MODE_RESET = 2'h0;
  localparam int         APM_MODE_HI    = 1;
  localparam int         APM_MODE_LO    = 0;

  // Clock and wake timing
  localparam int CLK_MHZ        = 10;
  localparam int WAKE_NS        = 5000;
  localparam int WAKE_CYC       = (WAKE_NS * CLK_MHZ + 999) / 1000;
  // Host start-low time; margin covers the device's pin sync and edge detect
  localparam int START_LOW_CYC  = WAKE_CYC + 4;
  localparam int CONV_NS        = 4600;
  localparam int CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_US         = 32000;
  localparam int CAL_CYC        = CAL_US * CLK_MHZ;
  localparam int CNT_W          = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;

  // Power states
  typedef enum logic [3:0] {
    APM_ST_NORMAL  = 4'b0001,
    APM_ST_FULL_PD = 4'b0010,
    APM_ST_PART_PD = 4'b0100,
    APM_ST_WAKING  = 4'b1000
  } apm_pwr_t;
endpackage

// ==== pkg/apm_if.sv ====
`timescale 1ns/1ps
interface apm_if;
  logic       conversion_start_n;
  logic       calibrate_n;
  logic       standby_n;
  logic       wr_valid;
  logic [1:0] wr_mode;
  logic       wr_start_conv;
  logic       wr_calibrate;
  logic       busy;
  logic [3:0] power_state;

  modport dev (
    input  conversion_start_n, calibrate_n, standby_n,
    input  wr_valid, wr_mode, wr_start_conv, wr_calibrate,
    output busy, power_state
  );
  modport host (
    output conversion_start_n, calibrate_n, standby_n,
    output wr_valid, wr_mode, wr_start_conv, wr_calibrate,
    input  busy, power_state
  );
endinterface

// ==== src/apm_host.sv ====
`timescale 1ns/1ps
module apm_host
  import apm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       req_pulse_conv,
  input  wire logic       req_write,
  input  wire logic [1:0] req_mode,
  input  wire logic       req_sw_conv,
  input  wire logic       req_sw_cal,
  input  wire logic       req_standby_n,
  output logic            req_ready,
  output logic            dev_busy,
  apm_if.host             bus
);
  import apm_pkg::*;

  logic [CNT_W-1:0] low_q;
  logic             pulse_q, stby_q, wr_q, conv_q, cal_q;
  logic [1:0]       mode_q, busy_s_q;

  // Ready once the start pulse is done and no write is pending
  assign req_ready = ~pulse_q & ~wr_q;

  // Start pulse held low for the full wake time before rising
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_q <= 1'b0;
      low_q   <= CNT_ZERO;
    end else if (clk_en) begin
      if (req_ready && req_pulse_conv) begin
        pulse_q <= 1'b1;
        low_q   <= CNT_W'(START_LOW_CYC);                                  // R8
      end else if (low_q != CNT_ZERO) begin
        low_q <= low_q - 1'b1;
      end else begin
        pulse_q <= 1'b0;
      end
    end
  end

  // One write per request; software conversion needs a power-up write first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q   <= 1'b0;
      mode_q <= APM_MODE_RESET;
      conv_q <= 1'b0;
      cal_q  <= 1'b0;
      stby_q <= 1'b1;
      busy_s_q <= 2'h0;
    end else if (clk_en) begin
      busy_s_q <= {busy_s_q[0], bus.busy};
      stby_q   <= req_standby_n;                                           // R16
      wr_q     <= req_ready & req_write;
      if (req_ready && req_write) begin
        // A conversion write always carries the power-up mode in the same write
        mode_q <= req_sw_conv ? APM_MODE_UP : req_mode;                    // R9
        conv_q <= req_sw_conv;
        cal_q  <= req_sw_cal;                                              // R11
      end
    end
  end

  assign bus.conversion_start_n = ~pulse_q;
  assign bus.calibrate_n        = 1'b1;                                    // R15
  assign bus.standby_n          = stby_q;
  assign bus.wr_valid           = wr_q;
  assign bus.wr_mode            = mode_q;
  assign bus.wr_start_conv      = conv_q;
  assign bus.wr_calibrate       = cal_q;
  assign dev_busy               = busy_s_q[1];                             // R14
endmodule

// ==== dv/apm_sva.sv ====
`timescale 1ns/1ps
module apm_sva
  import apm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       conversion_start_n,
  input wire logic       standby_n,
  input wire logic       wr_valid,
  input wire logic [1:0] wr_mode,
  input wire logic       busy,
  input wire logic [3:0] power_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [5:0] wcnt_q;
  logic [5:0] wcnt_d;
  wire        wake = power_state == APM_ST_WAKING;
  wire        up   = power_state == APM_ST_NORMAL;
  // Shadow of the mode field; a completed write lands on the next edge
  assign mode_d = wr_valid ? wr_mode : mode_q;
  assign wcnt_d = wake ? wcnt_q + 6'h01 : 6'h00;
  always_ff @(posedge sys_clk) begin
    mode_q <= rst ? APM_MODE_RESET : mode_d;
    wcnt_q <= rst ? 6'h00 : wcnt_d;
  end
  a_full_mode_write: assert property (wr_valid && wr_mode == APM_MODE_FULL |=>
    power_state == APM_ST_FULL_PD) else $error("full power-down write missed");
  a_part_mode_write: assert property (wr_valid && wr_mode == APM_MODE_PART && !busy |=>
    power_state == APM_ST_PART_PD) else $error("partial power-down write missed");
  a_up_mode_write: assert property (wr_valid && wr_mode == APM_MODE_UP |-> ##[1:60] up)
    else $error("power-up write never reached normal");
  a_up_stays_normal: assert property (mode_q == APM_MODE_UP && !wr_valid && up |=> up)
    else $error("left normal in power-up mode");
  a_full_stays_down: assert property (mode_q == APM_MODE_FULL && !wr_valid &&
    power_state == APM_ST_FULL_PD |=> power_state == APM_ST_FULL_PD) else $error("woke in full mode");
  a_down_on_busy_fall: assert property (mode_q == APM_MODE_PIN && !standby_n && !wr_valid &&
    $fell(busy) |-> ##[0:1] power_state == APM_ST_FULL_PD) else $error("no power-down at end");
  a_start_wakes: assert property (mode_q == APM_MODE_PIN && power_state == APM_ST_FULL_PD &&
    $fell(conversion_start_n) |-> ##[1:5] wake) else $error("start edge did not wake");
  a_wake_length: assert property ($fell(wake) |-> wcnt_q == WAKE_CYC)
    else $error("wake time wrong");
  a_part_needs_cmd: assert property (power_state == APM_ST_PART_PD |-> mode_q == APM_MODE_PART)
    else $error("partial power-down not commanded");
  c_part: cover property (power_state == APM_ST_PART_PD);
  c_wake: cover property ($fell(wake));
  c_conv: cover property ($fell(busy));
endmodule

// ==== dv/adc_power_management_bench.sv ====
`timescale 1ns/1ps
module adc_power_management_bench;
  import apm_pkg::*;
  logic       sys_clk, rst, req_pulse_conv, req_write, req_sw_conv, req_standby_n;
  logic [1:0] req_mode;
  logic       req_ready, dev_busy;
  int         err_count, n_checks;
  apm_if bus ();
  apm_device apm_device_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .bus(bus.dev));
  // Software calibration tied off: its fixed 32 ms busy would dwarf the run
  apm_host apm_host_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .req_pulse_conv(req_pulse_conv), .req_write(req_write), .req_mode(req_mode),
    .req_sw_conv(req_sw_conv), .req_sw_cal(1'b0), .req_standby_n(req_standby_n),
    .req_ready(req_ready), .dev_busy(dev_busy), .bus(bus.host));
  apm_sva apm_sva_i (.sys_clk(sys_clk), .rst(rst), .conversion_start_n(bus.conversion_start_n),
    .standby_n(bus.standby_n), .wr_valid(bus.wr_valid), .wr_mode(bus.wr_mode),
    .busy(bus.busy), .power_state(bus.power_state));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded waits, then judge whatever is there
  task automatic wait_st(input logic [3:0] exp, input int lim);
    for (int i = 0; i < lim && bus.power_state !== exp; i++) @(negedge sys_clk);
    check(bus.power_state, exp);
  endtask
  task automatic wait_busy(input logic b, input int lim);
    for (int i = 0; i < lim && bus.busy !== b; i++) @(negedge sys_clk);
    check({3'h0, bus.busy}, {3'h0, b});
  endtask
  // One host request, held a single cycle once the host is ready
  task automatic req(input logic [1:0] m, input logic w, input logic sw, input logic p);
    for (int i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    req_mode = m;
    {req_write, req_sw_conv, req_pulse_conv} = {w, sw, p};
    @(negedge sys_clk);
    {req_write, req_sw_conv, req_pulse_conv} = 3'h0;
  endtask
  task automatic t_sleep_conv;
    wait_st(APM_ST_FULL_PD, 20);
    req(APM_MODE_PIN, 1'b0, 1'b0, 1'b1);
    wait_st(APM_ST_WAKING, 10);
    wait_st(APM_ST_NORMAL, 60);
    wait_busy(1'b1, 80);
    wait_busy(1'b0, 60);
    wait_st(APM_ST_FULL_PD, 3);
  endtask
  task automatic t_standby_high;
    req_standby_n = 1'b1;
    req(APM_MODE_PIN, 1'b0, 1'b0, 1'b1);
    wait_st(APM_ST_NORMAL, 70);
    wait_busy(1'b1, 80);
    repeat (3) @(negedge sys_clk);
    check({3'h0, dev_busy}, 4'h1);
    wait_busy(1'b0, 60);
    repeat (10) @(negedge sys_clk);
    check(bus.power_state, APM_ST_NORMAL);
    req_standby_n = 1'b0;
  endtask
  task automatic t_modes;
    req(APM_MODE_UP, 1'b1, 1'b0, 1'b0);
    wait_st(APM_ST_NORMAL, 60);
    req(APM_MODE_UP, 1'b1, 1'b1, 1'b0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 60);
    repeat (5) @(negedge sys_clk);
    check(bus.power_state, APM_ST_NORMAL);
    req(APM_MODE_FULL, 1'b1, 1'b0, 1'b0);
    wait_st(APM_ST_FULL_PD, 5);
    req(APM_MODE_FULL, 1'b0, 1'b0, 1'b1);
    repeat (80) @(negedge sys_clk);
    check(bus.power_state, APM_ST_FULL_PD);
    req(APM_MODE_PART, 1'b1, 1'b0, 1'b0);
    wait_st(APM_ST_PART_PD, 5);
    req(APM_MODE_UP, 1'b1, 1'b0, 1'b0);
    wait_st(APM_ST_NORMAL, 60);
  endtask
  // A few hundred cycles are expected; this span is far beyond them
  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
  initial begin
    {req_pulse_conv, req_write, req_sw_conv, req_standby_n} = 4'h0;
    req_mode = APM_MODE_PIN;
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_sleep_conv();
    t_standby_high();
    t_modes();
    print_verdict();
  end
endmodule
